/* File: src/pdw_pkg.sv */
/*
 * Constants, register map and carrier types for the port wake-up block.
 * Assumes a single clock pclk at 50 MHz and APB register access.
 */
// Function
// - De-bounce tap chosen among three prescaler taps.
// - Slowest tap selected after reset.
// - Detect one pin toggling, others held low.
// - Stable two periods sets port A flag.
// - Port A flag stops its sampling clock.
// - Wake-source write clears flag, restarts clock.
// - Halt request while either wake flag set.
// - Port interrupt when request and enabled.
// - Port B same filter, own flag.
// - Port B pins input after reset.
// - Per-bit direction from direction write.
// - Output latch drives only output pins.
// - Input read gives pins or latches.
// - Pull-low follows direction write operand.
// - Pull-low forced off on output pins.
// - Selected external edge sets request flag.
// - Request with halt enable sets start flag.
// - Request with interrupt enable gives interrupt.
package pdw_pkg;
	// Register byte offsets.
	localparam logic [7:0] OFS_CLK_SEL = 8'h00;
	localparam logic [7:0] OFS_WAKE_SEL = 8'h04;
	localparam logic [7:0] OFS_B_DIR = 8'h08;
	localparam logic [7:0] OFS_B_OUT = 8'h0c;
	localparam logic [7:0] OFS_B_IN = 8'h10;
	localparam logic [7:0] OFS_CTRL = 8'h14;
	localparam logic [7:0] OFS_STATUS = 8'h18;
	localparam logic [7:0] OFS_EXT_CLR = 8'h1c;
	// Tap select codes.
	localparam logic [1:0] TAP_DIV10 = 2'h0;
	localparam logic [1:0] TAP_DIV8 = 2'h1;
	localparam logic [1:0] TAP_DIV6 = 2'h2;
	// Nominal filter times in ms per tap.
	localparam int TAP_DIV10_MS = 32;
	localparam int TAP_DIV8_MS = 8;
	localparam int TAP_DIV6_MS = 2;
	localparam int CLK_HZ = 50000000;
	// Half of the filter time is one de-bounce period, since two periods are needed.
	localparam int TAP10_CYC = CLK_HZ / 1000 * TAP_DIV10_MS / 2;
	localparam int TAP8_CYC = CLK_HZ / 1000 * TAP_DIV8_MS / 2;
	localparam int TAP6_CYC = CLK_HZ / 1000 * TAP_DIV6_MS / 2;
	localparam int STABLE_TICKS = 2;
	// Bit positions in the control register.
	localparam int CTRL_PORT_INT_EN = 0;
	localparam int CTRL_EXT_HALT_EN = 1;
	localparam int CTRL_EXT_INT_EN = 2;
	// Bit positions in the status register.
	localparam int ST_A_WAKE = 0;
	localparam int ST_B_WAKE = 1;
	localparam int ST_PORT_HALT = 2;
	localparam int ST_EXT_HALT = 3;
	localparam int ST_EXT_START = 4;
	localparam logic [31:0] RESET_WORD = 32'h0000_0000;

	// APB request as a carrier.
	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [7:0] paddr;
		logic [31:0] pwdata;
	} pdw_apb_req_t;

	// Port B pad control group.
	typedef struct packed {
		logic [3:0] out;
		logic [3:0] oe_n;
		logic [3:0] pull_en;
	} pdw_pad_t;
endpackage : pdw_pkg

/* File: src/pdw_sync.sv */
/*
 * Two flip-flop synchroniser for a bus of pin levels.
 * Assumes the inputs are asynchronous to pclk.
 */
module pdw_sync #(
	parameter int WIDTH = 4
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	// Both stages held in one packed state.
	typedef struct packed {
		logic [WIDTH-1:0] s1;
		logic [WIDTH-1:0] s2;
	} pdw_sync_st_t;

	pdw_sync_st_t st_reg;
	pdw_sync_st_t st_next;

	// The first stage feeds only the second stage.
	always_comb
	begin
		st_next.s1 = async_in;
		st_next.s2 = st_reg.s1;
	end

	// Registers clear to zero under reset.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			st_reg <= '0;
		else
			st_reg <= st_next;
	end

	assign sync_out = st_reg.s2;
endmodule : pdw_sync

/* File: src/pdw_debounce.sv */
/*
 * De-bounce and wake detector for one 4-bit port.
 * Assumes synchronised pins, a one-cycle sampling tick and a clear pulse.
 */
module pdw_debounce #(
	parameter int WIDTH = 4
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic tick,
	input wire logic [WIDTH-1:0] pins,
	input wire logic [WIDTH-1:0] enable,
	input wire logic clear,
	output logic wake_flag
);
	// Whole state of the detector.
	typedef struct packed {
		logic [WIDTH-1:0] ref_lvl;
		logic [WIDTH-1:0] cand;
		logic [1:0] cnt;
		logic flag;
	} pdw_db_st_t;

	pdw_db_st_t st_reg;
	pdw_db_st_t st_next;
	logic [WIDTH-1:0] diff;
	logic one_pin;

	// Exactly one enabled pin differs and every other pin is low.
	always_comb
	begin
		diff = (pins ^ st_reg.ref_lvl) & enable;
		one_pin = 1'b0;
		for (int i = 0; i < WIDTH; i++)
			if (diff == WIDTH'(1 << i) && (pins & ~WIDTH'(1 << i)) == '0)
				one_pin = 1'b1;
	end

	// Sampling runs only on ticks while the flag is clear.
	always_comb
	begin
		st_next = st_reg;
		if (clear)
		begin
			st_next.flag = 1'b0;
			st_next.cnt = '0;
			st_next.ref_lvl = pins;
		end
		else if (tick && !st_reg.flag)
		begin
			if (one_pin && pins == st_reg.cand)
			begin
				if (st_reg.cnt == 2'(pdw_pkg::STABLE_TICKS - 1))
				begin
					st_next.flag = 1'b1;
					st_next.ref_lvl = pins;
					st_next.cnt = '0;
				end
				else
					st_next.cnt = st_reg.cnt + 2'h1;
			end
			else
			begin
				// A new or broken change restarts the count.
				st_next.cand = pins;
				st_next.cnt = one_pin ? 2'h1 : 2'h0;
				if (!one_pin)
					st_next.ref_lvl = pins & ~enable | st_reg.ref_lvl & enable;
			end
		end
	end

	// Registers reset to idle.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			st_reg <= '0;
		else
			st_reg <= st_next;
	end

	assign wake_flag = st_reg.flag;
endmodule : pdw_debounce

/* File: src/pdw_top.sv */
/*
 * Port wake-up block: tap prescaler, two de-bounced ports, port B I/O,
 * external pin edge logic and an APB register slave.
 * Assumes pclk at 50 MHz, asynchronous pins and an APB master.
 */
module pdw_top #(
	// Clock cycles per sampling period of the slowest tap.
	parameter int TAP10_CYC = pdw_pkg::TAP10_CYC,
	// Clock cycles per sampling period of the middle tap.
	parameter int TAP8_CYC = pdw_pkg::TAP8_CYC,
	// Clock cycles per sampling period of the fastest tap.
	parameter int TAP6_CYC = pdw_pkg::TAP6_CYC,
	// Set when the pull-low devices of port B are fitted.
	parameter bit PULL_FITTED = 1'b1,
	// Set for a rising active edge on the external pin, clear for a falling one.
	parameter bit EXT_RISING = 1'b1
) (
	// Clock and asynchronous active-low reset.
	input wire logic pclk,
	input wire logic presetn,
	// APB slave request.
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	// APB slave answer.
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Port A pin levels.
	input wire logic [3:0] port_a_in,
	// Port B pin levels and pad controls.
	input wire logic [3:0] port_b_in,
	output logic [3:0] port_b_out,
	output logic [3:0] port_b_oe_n,
	output logic [3:0] port_b_pull_en,
	// External interrupt pin.
	input wire logic ext_int_pin,
	// Interrupt and halt release outputs.
	output logic port_irq,
	output logic ext_irq,
	output logic halt_release
);
	// Whole register state.
	typedef struct packed {
		// Selected de-bounce tap code.
		logic [1:0] tap_sel;
		// Port A pins that may wake the core.
		logic [3:0] a_wake_en;
		// Port B pins that may wake the core.
		logic [3:0] b_wake_en;
		// Port B direction, a one for an output.
		logic [3:0] b_dir;
		// Port B output latches.
		logic [3:0] b_latch;
		// Port B pull-low enables as written.
		logic [3:0] b_pull;
		// Port interrupt enable.
		logic port_int_en;
		// External halt-release enable.
		logic ext_halt_en;
		// External interrupt enable.
		logic ext_int_en;
		// External halt-release request flag.
		logic ext_halt_req;
		// External start condition flag.
		logic ext_start;
		// Previous synchronised external pin level.
		logic ext_prev;
		// Prescaler count within one sampling period.
		logic [31:0] tap_cnt;
		// Read data held for the access phase.
		logic [31:0] rdata;
	} pdw_top_st_t;

	// Registered state.
	pdw_top_st_t st_reg;
	// Next value of the state.
	pdw_top_st_t st_next;
	// Bus request carrier.
	pdw_pkg::pdw_apb_req_t req;
	// Port B pad control carrier.
	pdw_pkg::pdw_pad_t pad;
	// Synchronised port A pins.
	logic [3:0] a_sync;
	// Synchronised port B pins.
	logic [3:0] b_sync;
	// Synchronised external pin.
	logic [0:0] ext_sync;
	// Port A start condition flag.
	logic a_wake_flag;
	// Port B start condition flag.
	logic b_wake_flag;
	// Shared port halt-release request.
	logic port_halt_req;
	// A write completes at this edge.
	logic wr_en;
	// A read setup cycle ends at this edge.
	logic rd_en;
	// The address names a register.
	logic hit;
	// One-cycle de-bounce sampling tick.
	logic tick;
	// Wake-source write that clears both port flags.
	logic wake_clear;
	// Active edge seen on the external pin.
	logic ext_edge;
	// Length of the current sampling period.
	logic [31:0] tap_len;
	// Port B input read value.
	logic [3:0] b_read;
	// Selected read word.
	logic [31:0] rd_mux;
	// Status word.
	logic [7:0] status;

	// Bus request gathered into one carrier.
	assign req = '{psel: psel, penable: penable, pwrite: pwrite, paddr: paddr, pwdata: pwdata};

	// Synchronisers for both ports and the external pin.
	// Port A pins.
	pdw_sync #(.WIDTH(4)) u_sync_a (
		.pclk(pclk),
		.presetn(presetn),
		.async_in(port_a_in),
		.sync_out(a_sync)
	);
	// Port B pins, read back from the pads.
	pdw_sync #(.WIDTH(4)) u_sync_b (
		.pclk(pclk),
		.presetn(presetn),
		.async_in(port_b_in),
		.sync_out(b_sync)
	);
	// External interrupt pin.
	pdw_sync #(.WIDTH(1)) u_sync_e (
		.pclk(pclk),
		.presetn(presetn),
		.async_in(ext_int_pin),
		.sync_out(ext_sync)
	);

	// The slave answers in the first access cycle; a write lands at that edge.
	assign wr_en = req.psel && req.penable && req.pwrite;
	// Read data is captured at the end of the setup cycle, so that it already
	// stands in a flip-flop when the access cycle completes.
	assign rd_en = req.psel && !req.penable && !req.pwrite;
	// No wait state is ever inserted.
	assign pready = 1'b1;
	assign hit = (req.paddr == pdw_pkg::OFS_CLK_SEL) || (req.paddr == pdw_pkg::OFS_WAKE_SEL)
		|| (req.paddr == pdw_pkg::OFS_B_DIR) || (req.paddr == pdw_pkg::OFS_B_OUT)
		|| (req.paddr == pdw_pkg::OFS_B_IN) || (req.paddr == pdw_pkg::OFS_CTRL)
		|| (req.paddr == pdw_pkg::OFS_STATUS) || (req.paddr == pdw_pkg::OFS_EXT_CLR);
	// Unmapped addresses answer with an error and read zero.
	assign pslverr = req.psel && req.penable && !hit;

	// Writing the wake-source register clears both port flags and restarts sampling.
	assign wake_clear = wr_en && req.paddr == pdw_pkg::OFS_WAKE_SEL;

	// Tap period length picked by the clock select.
	always_comb
	begin
		unique case (st_reg.tap_sel)
			pdw_pkg::TAP_DIV8: tap_len = 32'(TAP8_CYC);
			pdw_pkg::TAP_DIV6: tap_len = 32'(TAP6_CYC);
			default: tap_len = 32'(TAP10_CYC);
		endcase
	end
	// One tick when the prescaler reaches the end of the period.
	assign tick = st_reg.tap_cnt >= tap_len - 32'h1;

	// Port A and port B de-bounce detectors.
	// Port A watches every pin that its wake mask enables.
	pdw_debounce #(.WIDTH(4)) u_db_a (
		.pclk(pclk),
		.presetn(presetn),
		.tick(tick),
		.pins(a_sync),
		.enable(st_reg.a_wake_en),
		.clear(wake_clear),
		.wake_flag(a_wake_flag)
	);
	// Port B wakes only from enabled pins in input mode.
	pdw_debounce #(.WIDTH(4)) u_db_b (
		.pclk(pclk),
		.presetn(presetn),
		.tick(tick),
		.pins(b_sync),
		.enable(st_reg.b_wake_en & ~st_reg.b_dir),
		.clear(wake_clear),
		.wake_flag(b_wake_flag)
	);

	// Shared halt request and the port interrupt.
	assign port_halt_req = a_wake_flag | b_wake_flag;
	assign port_irq = port_halt_req & st_reg.port_int_en;
	assign ext_irq = st_reg.ext_halt_req & st_reg.ext_int_en;
	assign halt_release = (port_halt_req | st_reg.ext_start);

	// Edge detect on the synchronised external pin, polarity by option.
	// The previous level and the synchroniser both reset low.
	assign ext_edge = EXT_RISING ? (ext_sync[0] & ~st_reg.ext_prev)
		: (~ext_sync[0] & st_reg.ext_prev);

	// Input reads take pin levels for inputs and latches for outputs.
	assign b_read = (b_sync & ~st_reg.b_dir) | (st_reg.b_latch & st_reg.b_dir);

	// Status word.
	always_comb
	begin
		status = '0;
		status[pdw_pkg::ST_A_WAKE] = a_wake_flag;
		status[pdw_pkg::ST_B_WAKE] = b_wake_flag;
		status[pdw_pkg::ST_PORT_HALT] = port_halt_req;
		status[pdw_pkg::ST_EXT_HALT] = st_reg.ext_halt_req;
		status[pdw_pkg::ST_EXT_START] = st_reg.ext_start;
	end

	// Read data multiplexer; narrow fields sit in the low bits.
	always_comb
	begin
		rd_mux = pdw_pkg::RESET_WORD;
		unique case (req.paddr)
			// Tap code.
			pdw_pkg::OFS_CLK_SEL: rd_mux[1:0] = st_reg.tap_sel;
			// Both wake masks, port B in the upper nibble.
			pdw_pkg::OFS_WAKE_SEL: rd_mux[7:0] = {st_reg.b_wake_en, st_reg.a_wake_en};
			// Pull enables above the direction bits.
			pdw_pkg::OFS_B_DIR: rd_mux[7:0] = {st_reg.b_pull, st_reg.b_dir};
			// Output latches.
			pdw_pkg::OFS_B_OUT: rd_mux[3:0] = st_reg.b_latch;
			// Pins for inputs, latches for outputs.
			pdw_pkg::OFS_B_IN: rd_mux[3:0] = b_read;
			// Enable bits.
			pdw_pkg::OFS_CTRL:
			begin
				rd_mux[pdw_pkg::CTRL_PORT_INT_EN] = st_reg.port_int_en;
				rd_mux[pdw_pkg::CTRL_EXT_HALT_EN] = st_reg.ext_halt_en;
				rd_mux[pdw_pkg::CTRL_EXT_INT_EN] = st_reg.ext_int_en;
			end
			// Flags.
			pdw_pkg::OFS_STATUS: rd_mux[7:0] = status;
			// The clear register and unmapped addresses read zero.
			default: rd_mux = pdw_pkg::RESET_WORD;
		endcase
	end

	// Next-state logic for registers, prescaler and external flags.
	always_comb
	begin
		st_next = st_reg;
		st_next.ext_prev = ext_sync[0];
		// Prescaler wraps each sampling period; a new tap restarts it.
		st_next.tap_cnt = tick ? 32'h0 : st_reg.tap_cnt + 32'h1;
		// The read word is held from the setup edge through the access cycle.
		if (rd_en)
			st_next.rdata = rd_mux;
		// Register writes land at the completing access edge.
		if (wr_en)
		begin
			unique case (req.paddr)
				pdw_pkg::OFS_CLK_SEL:
				begin
					// Code 3 is not a tap and selects the slowest one.
					st_next.tap_sel = (req.pwdata[1:0] == pdw_pkg::TAP_DIV8
						|| req.pwdata[1:0] == pdw_pkg::TAP_DIV6)
						? req.pwdata[1:0] : pdw_pkg::TAP_DIV10;
					st_next.tap_cnt = 32'h0;
				end
				// Wake masks; the same write clears both port flags.
				pdw_pkg::OFS_WAKE_SEL:
				begin
					st_next.a_wake_en = req.pwdata[3:0];
					st_next.b_wake_en = req.pwdata[7:4];
				end
				// Direction and pull-low enables in one write.
				pdw_pkg::OFS_B_DIR:
				begin
					st_next.b_dir = req.pwdata[3:0];
					st_next.b_pull = req.pwdata[7:4];
				end
				// Output latches load even while the pins are inputs.
				pdw_pkg::OFS_B_OUT: st_next.b_latch = req.pwdata[3:0];
				pdw_pkg::OFS_CTRL:
				begin
					st_next.port_int_en = req.pwdata[pdw_pkg::CTRL_PORT_INT_EN];
					st_next.ext_halt_en = req.pwdata[pdw_pkg::CTRL_EXT_HALT_EN];
					st_next.ext_int_en = req.pwdata[pdw_pkg::CTRL_EXT_INT_EN];
				end
				// External flag clear.
				pdw_pkg::OFS_EXT_CLR:
				begin
					// Writing ones clears the external flags.
					if (req.pwdata[pdw_pkg::ST_EXT_HALT])
						st_next.ext_halt_req = 1'b0;
					if (req.pwdata[pdw_pkg::ST_EXT_START])
						st_next.ext_start = 1'b0;
				end
				default:
				begin
				end
			endcase
		end
		// A fresh edge wins over a clear in the same cycle.
		if (ext_edge)
			st_next.ext_halt_req = 1'b1;
		if ((ext_edge || st_reg.ext_halt_req) && st_reg.ext_halt_en
			&& !(wr_en && req.paddr == pdw_pkg::OFS_EXT_CLR
			&& req.pwdata[pdw_pkg::ST_EXT_HALT] && !ext_edge))
			st_next.ext_start = 1'b1;
	end

	// Reset leaves port B as inputs and the slowest tap selected.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			st_reg <= '0;
			st_reg.tap_sel <= pdw_pkg::TAP_DIV10;
			st_reg.b_dir <= 4'h0;
		end
		else
			st_reg <= st_next;
	end

	// Pads: latch drives output pins only, pull-low off on outputs.
	always_comb
	begin
		// The latch is always presented; the enable decides whether it drives.
		pad.out = st_reg.b_latch;
		// Enable is low on output pins, so reset leaves every pin an input.
		pad.oe_n = ~st_reg.b_dir;
		// Pull-low only where fitted and only on input pins.
		pad.pull_en = PULL_FITTED ? (st_reg.b_pull & ~st_reg.b_dir) : 4'h0;
	end
	assign port_b_out = pad.out;
	assign port_b_oe_n = pad.oe_n;
	assign port_b_pull_en = pad.pull_en;
	assign prdata = st_reg.rdata;
endmodule : pdw_top

/* File: dv/pdw_chk.sv */
/*
 * Assertions on the ports of the port wake-up block.
 * Assumes pclk and presetn as the only clock and reset.
 */
module pdw_chk (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [3:0] port_a_in,
	input wire logic [3:0] port_b_in,
	input wire logic [3:0] port_b_out,
	input wire logic [3:0] port_b_oe_n,
	input wire logic [3:0] port_b_pull_en,
	input wire logic ext_int_pin,
	input wire logic port_irq,
	input wire logic ext_irq,
	input wire logic halt_release
);
	// A write that completes at this edge.
	wire logic wr = psel && penable && pwrite;
	// Writes to the port B direction and latch.
	wire logic wr_dir = wr && paddr == pdw_pkg::OFS_B_DIR;
	wire logic wr_out = wr && paddr == pdw_pkg::OFS_B_OUT;
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	reset_input_a: assert property (
		$rose(presetn) |-> port_b_oe_n == 4'hf) else $error("Port B not input.");
	dir_write_a: assert property (
		wr_dir |=> port_b_oe_n == ~$past(pwdata[3:0])) else $error("Bad direction.");
	pull_follow_a: assert property (
		wr_dir |=> port_b_pull_en == ($past(pwdata[7:4]) & ~$past(pwdata[3:0])))
		else $error("Bad pull.");
	pull_off_a: assert property (
		(port_b_pull_en & ~port_b_oe_n) == 4'h0) else $error("Pull on output.");
	latch_drive_a: assert property (
		wr_out |=> (port_b_out & ~port_b_oe_n) == ($past(pwdata[3:0]) & ~port_b_oe_n))
		else $error("Bad latch.");
	irq_halt_a: assert property (
		port_irq |-> halt_release) else $error("Irq without halt.");
	wake_clear_a: assert property (
		$fell(port_irq) |-> $past(wr && (paddr == pdw_pkg::OFS_WAKE_SEL
		|| paddr == pdw_pkg::OFS_CTRL))) else $error("Port irq dropped.");
	ext_clear_a: assert property (
		$fell(ext_irq) |-> $past(wr && (paddr == pdw_pkg::OFS_EXT_CLR
		|| paddr == pdw_pkg::OFS_CTRL))) else $error("Ext irq dropped.");
	ext_sync_a: assert property (
		$rose(ext_irq) && !$past(wr) |-> $past(ext_int_pin, 3)) else $error("Ext too early.");
	// Main scenarios.
	cover property ($rose(port_irq));
	cover property ($rose(ext_irq));
	cover property (pslverr);
endmodule : pdw_chk

bind pdw_top pdw_chk chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
	.prdata, .pready, .pslverr, .port_a_in, .port_b_in, .port_b_out, .port_b_oe_n,
	.port_b_pull_en, .ext_int_pin, .port_irq, .ext_irq, .halt_release);

/* File: dv/pdw_keys.sv */
/*
 * Key and signal model for the port pins and the external pin.
 * Assumes the bench sets key levels; a pressed key drives high.
 */
module pdw_keys (
	input wire logic pclk,
	input wire logic [3:0] key_a,
	input wire logic [3:0] key_b,
	input wire logic key_e,
	input wire logic [3:0] port_b_out,
	input wire logic [3:0] port_b_oe_n,
	input wire logic [3:0] port_b_pull_en,
	output logic [3:0] port_a_in,
	output logic [3:0] port_b_in,
	output logic ext_int_pin
);
	timeunit 1ns;
	timeprecision 1ps;
	// A floating pad shows a level that changes every cycle.
	logic float_lvl = 1'b0;
	// Toggles the floating level.
	always @(posedge pclk) float_lvl <= ~float_lvl;
	// Port A and the external pin follow their keys.
	assign port_a_in = key_a;
	assign ext_int_pin = key_e;
	// A pad shows its driver, else a pressed key, else the pull-low.
	always_comb
	begin
		for (int i = 0; i < 4; i++)
			port_b_in[i] = !port_b_oe_n[i] ? port_b_out[i] :
				key_b[i] ? 1'b1 : port_b_pull_en[i] ? 1'b0 : float_lvl;
	end
endmodule : pdw_keys

/* File: dv/test_port_debounce_wakeup.sv */
/*
 * Self-checking bench for the port wake-up block.
 * Assumes short tap parameters and the key model on the pins.
 */
module test_port_debounce_wakeup;
	timeunit 1ns;
	timeprecision 1ps;
	// Short tap periods keep the run brief.
	localparam int T10 = 8;
	localparam int T8 = 4;
	localparam int T6 = 2;
	// A port B setting and the pad state it should give.
	typedef struct packed {
		logic [3:0] lat;
		logic [7:0] dir;
		logic [3:0] key;
		logic [3:0] oe_n;
		logic [3:0] pull;
		logic [3:0] rd;
	} pdw_row_t;
	pdw_row_t rows [4] = '{'{4'ha, 8'h0f, 4'h0, 4'h0, 4'h0, 4'ha},
		'{4'h5, 8'hf3, 4'h4, 4'hc, 4'hc, 4'h5}, '{4'h0, 8'hf0, 4'h9, 4'hf, 4'hf, 4'h9},
		'{4'hf, 8'hf8, 4'h2, 4'h7, 4'h7, 4'ha}};
	int tap [3] = '{T10, T8, T6};
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, q;
	logic pready, pslverr, port_irq, ext_irq, halt_release, ext_int_pin, serr, key_e = 1'b0;
	logic [3:0] port_a_in, port_b_in, port_b_out, port_b_oe_n, port_b_pull_en;
	logic [3:0] key_a = 4'h0, key_b = 4'h0;
	int err_count = 0, compares = 0, n;
	// Free-running clock.
	always #10 pclk = ~pclk;
	pdw_top #(.TAP10_CYC(T10), .TAP8_CYC(T8), .TAP6_CYC(T6)) uut (.pclk, .presetn, .psel,
		.penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .port_a_in, .port_b_in,
		.port_b_out, .port_b_oe_n, .port_b_pull_en, .ext_int_pin, .port_irq, .ext_irq,
		.halt_release);
	pdw_keys keys (.pclk, .key_a, .key_b, .key_e, .port_b_out, .port_b_oe_n, .port_b_pull_en,
		.port_a_in, .port_b_in, .ext_int_pin);
	// Prints the counts and the verdict, then stops.
	task results;
		$display("errors %0d compares %0d", err_count, compares);
		if (err_count == 0 && compares > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : results
	// Counts a comparison and reports a mismatch.
	task chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp)
		begin
			err_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	// One APB transfer; error and read data are taken at the completing edge.
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		serr = pslverr;
		q = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb
	// Waits a bounded time for the halt release, looking at falling edges
	// so that a flag set at a rising edge has settled.
	task wait_hr(input int lim);
		n = 0;
		while (halt_release !== 1'b1 && n < lim)
		begin
			@(negedge pclk);
			n++;
		end
		@(posedge pclk);
	endtask : wait_hr
	// Main sequence.
	initial
	begin
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		chk(32'({port_b_oe_n, port_b_pull_en, port_b_out}), 32'hf00);
		chk(32'({port_irq, ext_irq, halt_release}), 32'h0);
		apb(1'b0, 8'h20, 32'h0);
		chk(32'({serr, q[3:0]}), 32'h10);
		foreach (rows[i])
		begin
			apb(1'b1, pdw_pkg::OFS_B_OUT, 32'(rows[i].lat));
			apb(1'b1, pdw_pkg::OFS_B_DIR, 32'(rows[i].dir));
			key_b <= rows[i].key;
			repeat (4) @(posedge pclk);
			apb(1'b0, pdw_pkg::OFS_B_IN, 32'h0);
			chk(q, 32'(rows[i].rd));
			chk(32'(port_b_oe_n), 32'(rows[i].oe_n));
			chk(32'(port_b_pull_en), 32'(rows[i].pull));
			chk(32'(port_b_out & ~port_b_oe_n), 32'(rows[i].lat & ~rows[i].oe_n));
		end
		apb(1'b1, pdw_pkg::OFS_B_DIR, 32'hf0);
		key_b <= 4'h0;
		apb(1'b1, pdw_pkg::OFS_CTRL, 32'h1);
		apb(1'b1, pdw_pkg::OFS_WAKE_SEL, 32'h0f);
		// The first pass runs on the tap left by reset.
		for (int t = 0; t < 3; t++)
		begin
			if (t > 0)
				apb(1'b1, pdw_pkg::OFS_CLK_SEL, 32'(t));
			key_a[0] <= ~key_a[0];
			wait_hr(60);
			chk(32'(n >= tap[t] + 2 && n <= 3 * tap[t] + 6), 32'h1);
			chk(32'(port_irq), 32'h1);
			apb(1'b0, pdw_pkg::OFS_STATUS, 32'h0);
			chk(q & 32'h1f, 32'h05);
			apb(1'b1, pdw_pkg::OFS_WAKE_SEL, 32'h0f);
			chk(32'(halt_release), 32'h0);
		end
		key_a[1] <= 1'b1;
		wait_hr(40);
		chk(32'(halt_release), 32'h0);
		key_a <= 4'h0;
		apb(1'b1, pdw_pkg::OFS_WAKE_SEL, 32'h20);
		key_b <= 4'h1;
		wait_hr(40);
		chk(32'(halt_release), 32'h0);
		key_b <= 4'h0;
		apb(1'b1, pdw_pkg::OFS_WAKE_SEL, 32'h20);
		key_b <= 4'h2;
		wait_hr(40);
		apb(1'b0, pdw_pkg::OFS_B_IN, 32'h0);
		chk(q, 32'h2);
		apb(1'b0, pdw_pkg::OFS_STATUS, 32'h0);
		chk(q & 32'h1f, 32'h06);
		apb(1'b1, pdw_pkg::OFS_CTRL, 32'h0);
		chk(32'({port_irq, halt_release}), 32'h1);
		apb(1'b1, pdw_pkg::OFS_WAKE_SEL, 32'h0);
		chk(32'(halt_release), 32'h0);
		apb(1'b1, pdw_pkg::OFS_CTRL, 32'h4);
		key_e <= 1'b1;
		repeat (8) @(posedge pclk);
		chk(32'({ext_irq, halt_release}), 32'h2);
		apb(1'b1, pdw_pkg::OFS_EXT_CLR, 32'h18);
		key_e <= 1'b0;
		repeat (8) @(posedge pclk);
		chk(32'(ext_irq), 32'h0);
		apb(1'b1, pdw_pkg::OFS_CTRL, 32'h6);
		key_e <= 1'b1;
		wait_hr(20);
		apb(1'b0, pdw_pkg::OFS_STATUS, 32'h0);
		chk(q & 32'h1f, 32'h18);
		chk(32'(ext_irq), 32'h1);
		apb(1'b1, pdw_pkg::OFS_CLK_SEL, 32'h3);
		apb(1'b0, pdw_pkg::OFS_CLK_SEL, 32'h0);
		chk(q, 32'(pdw_pkg::TAP_DIV10));
		results;
	end
	// Cuts a hang short.
	initial
	begin
		#200us;
		err_count++;
		results;
	end
endmodule : test_port_debounce_wakeup
